/* File: src/tick_pkg.sv */
// Constants, field positions and state types of the prescaled tick counter.
// Assumes a single clock domain on hclk with an active-low async reset.
package tick_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the AHB-Lite bus)
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_LOW     = 5'h04;
    localparam logic [4:0] OFS_BUFFER  = 5'h08;
    localparam logic [4:0] OFS_STATUS  = 5'h0C;
    localparam logic [4:0] OFS_IRQ     = 5'h10;

    // ----------------------------------------------------------------
    // Control register fields and reset values
    // ----------------------------------------------------------------
    localparam int         RUN_BIT      = 7;
    localparam int         WIDTH_BIT    = 6;
    localparam int         SOURCE_BIT   = 5;
    localparam int         EDGE_BIT     = 4;
    localparam int         BYPASS_BIT   = 3;
    localparam int         RATIO_MSB    = 2;
    localparam int         RATIO_LSB    = 0;
    localparam int         OVF_BIT      = 0;
    localparam int         IRQ_EN_BIT   = 0;
    localparam logic [7:0] CTRL_RESET   = 8'hFF;
    localparam logic [7:0] BYTE_MAX     = 8'hFF;
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  hbuf;
        logic        ovf;
        logic        irq_en;
        logic [1:0]  inhibit;
        logic        wr_pend;
        logic [4:0]  wr_addr;
        logic [31:0] rdata;
    } core_state_t;

    typedef struct packed {
        logic [7:0] cnt;
    } prescale_state_t;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } edge_state_t;

endpackage : tick_pkg

/* File: src/prescale_if.sv */
// Carrier between the counter core and its prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface prescale_if;
    logic       src_tick;
    logic       clear;
    logic [2:0] ratio;
    logic       pre_tick;

    modport core      (output src_tick, output clear, output ratio,
                       input pre_tick);
    modport prescaler (input src_tick, input clear, input ratio,
                       output pre_tick);
endinterface : prescale_if

/* File: src/tick_prescaler.sv */
// Eight-bit prescaler with power-of-two ratio select.
// Assumes the core gates src_tick and pulses clear for one cycle.
`timescale 1ns/100ps
module tick_prescaler
    import tick_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    prescale_if.prescaler    pif
);

    prescale_state_t q;
    prescale_state_t d;
    logic [7:0]      mask;

    // Ratio 000 divides by two, 111 by 256.
    assign mask = BYTE_MAX >> (3'h7 - pif.ratio);  // see RQ9
    assign pif.pre_tick = pif.src_tick && ((q.cnt & mask) == mask);

    always_comb begin
        d = q;
        if (pif.clear) begin
            d.cnt = 8'h00;  // see RQ10
        end else if (pif.src_tick) begin
            d.cnt = q.cnt + 8'h01;  // see RQ8
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : tick_prescaler

/* File: src/tick_edge_sync.sv */
// Synchroniser and edge picker for the external count pin.
// Assumes the pin is asynchronous to hclk.
`timescale 1ns/100ps
module tick_edge_sync
    import tick_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ext_count_pin,
    input  wire logic edge_select,
    output logic      ext_edge
);

    edge_state_t q;
    edge_state_t d;

    always_comb begin
        d      = q;
        d.meta = ext_count_pin;  // see RQ5
        d.sync = q.meta;
        d.prev = q.sync;
    end

    // Only the second stage and its delayed copy feed the edge picker.
    assign ext_edge = edge_select ? (q.prev && !q.sync)  // see RQ4
                                  : (!q.prev && q.sync);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : tick_edge_sync

/* File: src/tick_counter.sv */
// Top of the 8/16-bit prescaled tick counter with its AHB-Lite slave.
// Assumes hclk is the instruction clock and sleep_mode is on hclk too.
//
// How it works
// RQ1 - Width select set gives an 8-bit counter, cleared gives 16 bits.
// RQ2 - Source select cleared counts instruction clocks, every clock with bypass set.
// RQ3 - Source select set counts transitions of the external count pin.
// RQ4 - Edge select cleared counts rising pin edges, set counts falling.
// RQ5 - The external pin is synchronised before it can cause an increment.
// RQ6 - A count write blocks counting for the next two clocks.
// RQ7 - Bypass set feeds the counter directly, cleared feeds it prescaled.
// RQ8 - The prescaler is an 8-bit counter hidden from software.
// RQ9 - Three ratio bits select 1:2 through 1:256, 111 being 1:256.
// RQ10 - With prescaler assigned, a count write clears the prescaler.
// RQ11 - A count write never changes the prescaler assignment.
// RQ12 - Prescaler assignment may change at any time while counting.
// RQ13 - In 16-bit mode software only sees a buffer for the high byte.
// RQ14 - Reading the low byte copies the real high byte into the buffer.
// RQ15 - Software writes the buffer first; low write loads it high.
// RQ16 - The control register is read/write and governs all operation.
// RQ17 - Overflow flag sets on wrap at 8 or 16 bits per width select.
// RQ18 - Enable bit masks the interrupt; software clears flag before enabling.
// RQ19 - Counting stops during sleep, so no overflow can wake the core.
// RQ20 - Run bit set counts, cleared halts and holds the value.
// RQ21 - In 8-bit mode only the low byte counts; high byte untouched.
`timescale 1ns/100ps
module tick_counter
    import tick_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_count_pin,
    input  wire logic        sleep_mode,
    output logic             overflow_irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    core_state_t q;
    core_state_t d;
    prescale_if  pif ();
    logic        accept;
    logic        rd_accept;
    logic        wr_low;
    logic        wr_ctrl;
    logic        wr_buf;
    logic        wr_stat;
    logic        wr_irq;
    logic        width8;
    logic        bypass;
    logic        active;
    logic        ext_edge;
    logic        tick;
    logic        advance;
    logic        ovf_set;
    logic [15:0] cnt16;
    logic [15:0] cnt16_inc;

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    tick_edge_sync u_edge (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ext_count_pin (ext_count_pin),
        .edge_select   (q.ctrl[EDGE_BIT]),
        .ext_edge      (ext_edge)
    );

    tick_prescaler u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pif     (pif)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Hsize is ignored; every register is one aligned word.
    assign accept    = hsel && hready && htrans[1];
    assign rd_accept = accept && !hwrite;
    assign wr_low    = q.wr_pend && (q.wr_addr == OFS_LOW);
    assign wr_ctrl   = q.wr_pend && (q.wr_addr == OFS_CONTROL);
    assign wr_buf    = q.wr_pend && (q.wr_addr == OFS_BUFFER);
    assign wr_stat   = q.wr_pend && (q.wr_addr == OFS_STATUS);
    assign wr_irq    = q.wr_pend && (q.wr_addr == OFS_IRQ);

    // ----------------------------------------------------------------
    // Count path
    // ----------------------------------------------------------------
    assign width8 = q.ctrl[WIDTH_BIT];  // see RQ1
    assign bypass = q.ctrl[BYPASS_BIT];
    assign active = q.ctrl[RUN_BIT] && !sleep_mode;  // see RQ19 see RQ20

    // Assignment switches at once; no stop is needed to change it.
    assign pif.src_tick = active && (q.ctrl[SOURCE_BIT] ? ext_edge  // see RQ3
                                                        : 1'b1);    // see RQ2
    assign pif.ratio    = q.ctrl[RATIO_MSB:RATIO_LSB];
    assign pif.clear    = wr_low && !bypass;  // see RQ10
    assign tick         = bypass ? pif.src_tick : pif.pre_tick;  // see RQ7 see RQ12
    assign advance      = tick && (q.inhibit == 2'h0);  // see RQ6

    assign cnt16     = {q.hi, q.lo};
    assign cnt16_inc = cnt16 + 16'h0001;
    assign ovf_set   = advance && (q.lo == BYTE_MAX)  // see RQ17
                       && (width8 || (q.hi == BYTE_MAX));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d         = q;
        d.wr_pend = accept && hwrite;
        d.wr_addr = haddr[4:0];
        if (q.inhibit != 2'h0) begin
            d.inhibit = q.inhibit - 2'h1;
        end
        if (advance) begin
            if (width8) begin
                d.lo = cnt16_inc[7:0];  // see RQ21
            end else begin
                {d.hi, d.lo} = cnt16_inc;
            end
        end
        // A write lands after counting, so the written value wins.
        if (wr_low) begin  // see RQ11
            d.lo      = hwdata[7:0];
            d.inhibit = INHIBIT_CYCLES;  // see RQ6
            if (!width8) begin
                d.hi = q.hbuf;  // see RQ15
            end
        end
        if (wr_ctrl) begin
            d.ctrl = hwdata[7:0];  // see RQ16
        end
        if (wr_buf) begin
            d.hbuf = hwdata[7:0];  // see RQ13
        end
        if (wr_stat && hwdata[OVF_BIT]) begin
            d.ovf = 1'b0;
        end
        if (wr_irq) begin
            d.irq_en = hwdata[IRQ_EN_BIT];  // see RQ18
        end
        // An overflow in the clearing cycle is kept.
        if (ovf_set) begin
            d.ovf = 1'b1;  // see RQ17
        end
        if (rd_accept) begin
            unique case (haddr[4:0])
                OFS_CONTROL: d.rdata = {24'h000000, q.ctrl};
                OFS_LOW: begin
                    d.rdata = {24'h000000, q.lo};
                    d.hbuf  = q.hi;  // see RQ14
                end
                OFS_BUFFER:  d.rdata = {24'h000000, q.hbuf};  // see RQ13
                OFS_STATUS:  d.rdata = {31'h00000000, q.ovf};
                OFS_IRQ:     d.rdata = {31'h00000000, q.irq_en};
                default:     d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q      <= '0;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Zero wait states keep reads coherent with the buffer copy.
    assign hrdata       = q.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign overflow_irq = q.ovf && q.irq_en;  // see RQ18

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_inhibit_load;
        @(posedge hclk) disable iff (!hresetn)
        wr_low |=> (q.inhibit == 2'h2);
    endproperty
    a_inhibit_load: assert property (p_inhibit_load)  // see RQ6
        else $error("Count write did not start the two-cycle inhibit.");

    property p_inhibit_hold;
        @(posedge hclk) disable iff (!hresetn)
        wr_low ##1 (!wr_low)[*2] |-> $stable(cnt16) ##1 $stable(cnt16);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)  // see RQ6
        else $error("Count moved during the inhibit after a write.");

    property p_width8_high;
        @(posedge hclk) disable iff (!hresetn)
        (width8 && !wr_low) |=> (q.hi == $past(q.hi));
    endproperty
    a_width8_high: assert property (p_width8_high)  // see RQ21
        else $error("High byte changed in 8-bit mode.");

    property p_wrap_flag;
        @(posedge hclk) disable iff (!hresetn)
        (advance && !wr_low && q.lo == 8'hFF && (width8 || q.hi == 8'hFF))
        |=> q.ovf && (q.lo == 8'h00);
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)  // see RQ17
        else $error("Wrap did not set the overflow flag.");

    property p_no_false_flag;
        @(posedge hclk) disable iff (!hresetn)
        (!q.ovf && !width8 && q.hi != 8'hFF) |=> !q.ovf;
    endproperty
    a_no_false_flag: assert property (p_no_false_flag)  // see RQ17
        else $error("Overflow flag set without a 16-bit wrap.");

    property p_read_copy;
        @(posedge hclk) disable iff (!hresetn)
        (rd_accept && haddr[4:0] == OFS_LOW)
        |=> (q.hbuf == $past(q.hi)) && (hrdata[7:0] == $past(q.lo));
    endproperty
    a_read_copy: assert property (p_read_copy)  // see RQ14
        else $error("Low-byte read did not latch the high byte.");

    property p_write_load;
        @(posedge hclk) disable iff (!hresetn)
        (wr_low && !width8) |=> (q.hi == $past(q.hbuf))
                                && (q.lo == $past(hwdata[7:0]));
    endproperty
    a_write_load: assert property (p_write_load)  // see RQ15
        else $error("Low-byte write did not load the buffered high byte.");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        (!q.ctrl[RUN_BIT] && !wr_low) |=> $stable(cnt16);
    endproperty
    a_halt: assert property (p_halt)  // see RQ20
        else $error("Counter moved while halted.");

    property p_sleep;
        @(posedge hclk) disable iff (!hresetn)
        (sleep_mode && !wr_low) |=> $stable(cnt16) && $stable(q.ovf)
                                    || $past(wr_stat);
    endproperty
    a_sleep: assert property (p_sleep)  // see RQ19
        else $error("Counter moved during sleep.");

    property p_direct_count;
        @(posedge hclk) disable iff (!hresetn)
        (active && bypass && !q.ctrl[SOURCE_BIT] && q.inhibit == 2'h0
         && !wr_low && width8)
        |=> (q.lo == $past(q.lo) + 8'h01);
    endproperty
    a_direct_count: assert property (p_direct_count)  // see RQ2 see RQ7
        else $error("Unprescaled internal count did not step each clock.");

    property p_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (q.ctrl == $past(hwdata[7:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)  // see RQ16
        else $error("Control write did not land.");

    property p_ctrl_kept;
        @(posedge hclk) disable iff (!hresetn)
        wr_low |=> $stable(q.ctrl);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept)  // see RQ11
        else $error("Count write changed the control register.");

    property p_buf_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_buf && !(rd_accept && haddr[4:0] == OFS_LOW))
        |=> (q.hbuf == $past(hwdata[7:0]));
    endproperty
    a_buf_write: assert property (p_buf_write)  // see RQ13
        else $error("Buffer write did not land in the buffer byte.");

    property p_ext_only;
        @(posedge hclk) disable iff (!hresetn)
        (q.ctrl[SOURCE_BIT] && bypass && !ext_edge && !wr_low)
        |=> $stable(cnt16);
    endproperty
    a_ext_only: assert property (p_ext_only)  // see RQ3
        else $error("Counter moved without a pin edge in counter mode.");

    property p_prescaled_only;
        @(posedge hclk) disable iff (!hresetn)
        (!bypass && !pif.pre_tick && !wr_low) |=> $stable(cnt16);
    endproperty
    a_prescaled_only: assert property (p_prescaled_only)  // see RQ7
        else $error("Counter moved without a prescaler tick.");

    property p_stat_clear;
        @(posedge hclk) disable iff (!hresetn)
        (wr_stat && hwdata[OVF_BIT] && !ovf_set) |=> !q.ovf;
    endproperty
    a_stat_clear: assert property (p_stat_clear)  // see RQ18
        else $error("Status write did not clear the overflow flag.");

endmodule : tick_counter

/* File: bench/tick_pin_model.sv */
// Behavioural source for the external count pin of the tick counter.
// Assumes the pin is sampled asynchronously; edges fall off hclk edges.
`timescale 1ns/100ps
module tick_pin_model (
    output logic pin
);

    // ----------------------------------------------------------------
    // Pin driver
    // ----------------------------------------------------------------
    // The pin idles low; a burst leaves it high so that rising and
    // falling edge counts differ by one.
    initial pin = 1'b0;

    task automatic burst(input int n, input int half);
        #1.3;
        repeat (n) begin
            pin = 1'b1;
            #(half * 4);
            pin = 1'b0;
            #(half * 4);
        end
        pin = 1'b1;
        #(half * 4);
    endtask : burst

    task automatic idle();
        pin = 1'b0;
    endtask : idle

endmodule : tick_pin_model

/* File: bench/tick_counter_tb_top.sv */
// Self-checking bench for the prescaled tick counter.
// Assumes a single AHB-Lite master and a zero-wait-state slave.
`timescale 1ns/100ps
module tick_counter_tb_top
    import tick_pkg::*;
();

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        hclk;
    logic        hresetn    = 1'b0;
    logic        hsel       = 1'b0;
    logic        hwrite     = 1'b0;
    logic        sleep_mode = 1'b0;
    logic        dph_chk    = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [31:0] hwdata     = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic [2:0]  hsize      = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        overflow_irq;
    logic        ext_count_pin;
    logic [31:0] exp_q[$];
    logic [15:0] lfsr_q     = 16'h1707;
    logic [7:0]  v;
    int          bad_count  = 0;
    int          n_tests    = 0;

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    tick_counter DUT (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .ext_count_pin (ext_count_pin),
        .sleep_mode    (sleep_mode),
        .overflow_irq  (overflow_irq)
    );

    tick_pin_model pin_model (
        .pin (ext_count_pin)
    );

    // ----------------------------------------------------------------
    // Helpers and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad_count++;
            results();
        end
    endtask : wait_rdy

    // One single transfer; a checked read notes its expectation first.
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [31:0] wd, input logic chk,
                       input logic [7:0] e, output logic [31:0] rd);
        haddr  <= {27'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        if (!w && chk) begin
            exp_q.push_back({24'h0, e});
            dph_chk <= 1'b1;
        end
        wait_rdy();
        dph_chk <= 1'b0;
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] wd);
        logic [31:0] x;
        bus(a, 1'b1, {24'h0, wd}, 1'b0, 8'h00, x);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, 1'b1, e, x);
    endtask : rd

    task automatic results();
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Read data monitor
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        if (dph_chk) begin
            if (exp_q.size() == 0) bad_count++;
            else check("read data", hrdata, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        #200000;
        bad_count++;
        results();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_CONTROL, CTRL_RESET);
        rd(OFS_LOW, 8'h00);
        rd(OFS_BUFFER, 8'h00);
        rd(OFS_STATUS, 8'h00);
        rd(5'h14, 8'h00);
        lfsr_q = lfsr_next(lfsr_q);
        v = {1'b0, lfsr_q[6:0]};
        wr(OFS_CONTROL, v);
        rd(OFS_CONTROL, v);
        // Each ratio code waits four and a half prescaled periods.
        for (int n = 0; n < 8; n++) begin
            v = 8'hC0 | 8'(n);
            wr(OFS_CONTROL, v);
            wr(OFS_LOW, 8'h00);
            repeat ((4 << (n + 1)) + (1 << n)) @(posedge hclk);
            // The 1:2 ratio loses its first tick to the write inhibit.
            rd(OFS_LOW, (n == 0) ? 8'h03 : 8'h04);
            rd(OFS_CONTROL, v);
        end
        wr(OFS_CONTROL, 8'hC8);
        wr(OFS_BUFFER, 8'h5A);
        wr(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'h00);
        rd(OFS_STATUS, 8'h01);
        wr(OFS_IRQ, 8'h01);
        @(negedge hclk);
        check("overflow irq", {31'h0, overflow_irq}, 32'h1);
        @(posedge hclk);
        wr(OFS_STATUS, 8'h01);
        @(negedge hclk);
        check("overflow irq", {31'h0, overflow_irq}, 32'h0);
        @(posedge hclk);
        sleep_mode <= 1'b1;
        wr(OFS_LOW, 8'h40);
        repeat (3) rd(OFS_LOW, 8'h40);
        // Halt before waking, or the count would step during the write.
        wr(OFS_CONTROL, 8'h08);
        sleep_mode <= 1'b0;
        rd(OFS_LOW, 8'h40);
        rd(OFS_BUFFER, 8'h00);
        lfsr_q = lfsr_next(lfsr_q);
        wr(OFS_BUFFER, lfsr_q[15:8]);
        wr(OFS_LOW, lfsr_q[7:0]);
        wr(OFS_BUFFER, 8'h33);
        rd(OFS_LOW, lfsr_q[7:0]);
        rd(OFS_BUFFER, lfsr_q[15:8]);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_BUFFER, 8'hFF);
        wr(OFS_CONTROL, 8'h88);
        wr(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'hFE);
        rd(OFS_LOW, 8'h00);
        rd(OFS_BUFFER, 8'h00);
        rd(OFS_STATUS, 8'h01);
        // Rising mode sees one edge more, since a burst ends high.
        for (int e = 0; e < 2; e++) begin
            wr(OFS_CONTROL, (e == 1) ? 8'hF8 : 8'hE8);
            wr(OFS_LOW, 8'h00);
            pin_model.burst(5, 3);
            repeat (8) @(posedge hclk);
            rd(OFS_LOW, (e == 1) ? 8'h05 : 8'h06);
            pin_model.idle();
            repeat (8) @(posedge hclk);
        end
        results();
    end

endmodule : tick_counter_tb_top
